/* dafe_adc_model.sv */
`timescale 1ns/1ps
module dafe_adc_model #(parameter int ADC_BITS = 12) (
  input wire logic gain_in,
  input wire logic [13:0] val_a_in,
  input wire logic [13:0] val_b_in,
  input wire logic [2:0] exp_in,
  output logic [13:0] mant_a_out,
  output logic [13:0] mant_b_out,
  output logic [2:0] exp_out
);
  // narrow converter: unused low bits held low
  logic [13:0] msk;
  assign msk = 14'h3FFF << (14 - ADC_BITS);
  assign mant_a_out = val_a_in & msk;
  assign mant_b_out = val_b_in & msk;
  assign exp_out = gain_in ? exp_in : 3'h0;
endmodule // dafe_adc_model

/* dafe_fifo.sv */
`timescale 1ns/1ps
module dafe_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  dafe_stream_if.snk wr,
  dafe_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic [WIDTH-1:0] dout_reg;
  logic dvalid_reg;
  wire logic full = (cnt_reg == (AW+1)'(DEPTH));
  wire logic empty = (cnt_reg == '0);
  // output register refills when drained or empty
  wire logic pop = !empty && (!dvalid_reg || rd.ready);
  wire logic push = wr.valid && !full;
  assign wr.ready = !full;
  assign rd.valid = dvalid_reg;
  assign rd.data = dout_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      dvalid_reg <= 1'b0;
      dout_reg <= '0;
    end else if (ce_in) begin
      if (push) begin
        mem_reg[wptr_reg] <= wr.data;
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        dout_reg <= mem_reg[rptr_reg];
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
        dvalid_reg <= 1'b1;
      end else if (rd.ready) begin
        dvalid_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dafe_fifo

/* dafe_frontend.sv */
`timescale 1ns/1ps
// Summary of operation
// - capture each port every rising mclk edge
// - ports take 14-bit mantissa, 3-bit exponent
// - mantissa signed two's complement, exponent unsigned
// - each channel selects port A or B
// - four channels share multiplexed port streams
// - separate qualifier pin per input port
// - four qualification modes per channel
// - level-high accepts only while pin high
// - falling mode captures edge after high-to-low
// - rising mode captures edge after low-to-high
// - blank mode zeroes sample while pin low
// - transition modes take one edge only
// - compute strobe fires every clock regardless
// - latency equals rdec*(cdec+7)+taps+26
module dafe_frontend
  import dafe_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [MANT_W-1:0] port_a_mantissa_in,
  input wire logic [EXP_W-1:0] port_a_exponent_in,
  input wire logic port_a_sample_qualifier_in,
  input wire logic [MANT_W-1:0] port_b_mantissa_in,
  input wire logic [EXP_W-1:0] port_b_exponent_in,
  input wire logic port_b_sample_qualifier_in,
  input wire logic [NUM_CH-1:0] ch_src_b_in,
  input wire logic [2*NUM_CH-1:0] ch_qual_mode_in,
  input wire logic [7:0] resamp_dec_in,
  input wire logic [7:0] comb_dec_in,
  input wire logic [7:0] fir_tap_count_in,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [CH_W-1:0] out_channel_out,
  output logic signed [MANT_W-1:0] out_mantissa_out,
  output logic [EXP_W-1:0] out_exponent_out,
  output logic [NUM_CH-1:0] compute_strobe_out,
  output logic [NUM_CH-1:0] overflow_out,
  output logic [LAT_W-1:0] latency_out
);
  // one captured sample per port per edge
  logic [MANT_W-1:0] a_mant_reg;
  logic [EXP_W-1:0] a_exp_reg;
  logic a_qual_reg;
  logic a_qual_prev_reg;
  logic [MANT_W-1:0] b_mant_reg;
  logic [EXP_W-1:0] b_exp_reg;
  logic b_qual_reg;
  logic b_qual_prev_reg;
  logic [NUM_CH-1:0] ch_valid_reg;
  logic [SAMPLE_W-1:0] ch_data_reg [NUM_CH];
  logic [CH_W-1:0] rr_reg;
  logic [NUM_CH-1:0] ovf_reg;
  logic [NUM_CH-1:0] strobe_reg;
  logic [LAT_W-1:0] lat_reg;
  logic ov_reg;
  logic [CH_W-1:0] och_reg;
  logic [MANT_W-1:0] omant_reg;
  logic [EXP_W-1:0] oexp_reg;

  function automatic logic qualify(
    input logic [1:0] mode,
    input logic cur,
    input logic prev
  );
    logic q;
    q = 1'b0;
    case (mode)
      DAFE_QUAL_FALL: q = prev && !cur;
      DAFE_QUAL_RISE: q = !prev && cur;
      DAFE_QUAL_HIGH: q = cur;
      DAFE_QUAL_BLANK: q = 1'b1;
      default: q = 1'b0;
    endcase
    return q;
  endfunction

  // per-channel source and qualification decode
  wire logic [NUM_CH-1:0] ch_take;
  wire logic [SAMPLE_W-1:0] ch_sample [NUM_CH];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // mode and source sampled live; held static by software
      wire logic [1:0] mode = ch_qual_mode_in[2*g+1:2*g];
      wire logic use_b = ch_src_b_in[g];
      wire logic cur = use_b ? b_qual_reg : a_qual_reg;
      wire logic prev = use_b ? b_qual_prev_reg : a_qual_prev_reg;
      wire logic [MANT_W-1:0] m = use_b ? b_mant_reg : a_mant_reg;
      wire logic [EXP_W-1:0] e = use_b ? b_exp_reg : a_exp_reg;
      wire logic blank = (mode == DAFE_QUAL_BLANK) && !cur;
      assign ch_take[g] = qualify(mode, cur, prev);
      // zero substitution clears exponent too, so scaling stays sane
      assign ch_sample[g] = blank ? {MANT_RESET, EXP_RESET} : {m, e};
    end
  endgenerate

  // round-robin pick among pending channels
  wire logic [CH_W-1:0] pick0 = rr_reg;
  wire logic [CH_W-1:0] pick1 = rr_reg + 2'd1;
  wire logic [CH_W-1:0] pick2 = rr_reg + 2'd2;
  wire logic [CH_W-1:0] pick3 = rr_reg + 2'd3;
  wire logic [CH_W-1:0] pick = ch_valid_reg[pick0] ? pick0 :
                               ch_valid_reg[pick1] ? pick1 :
                               ch_valid_reg[pick2] ? pick2 : pick3;
  wire logic any_pending = |ch_valid_reg;

  dafe_stream_if #(.W(SAMPLE_W + CH_W)) fin ();
  dafe_stream_if #(.W(SAMPLE_W + CH_W)) fout ();
  assign fin.valid = any_pending;
  assign fin.data = {pick, ch_data_reg[pick]};
  wire logic grant = any_pending && fin.ready;

  dafe_fifo #(
    .WIDTH(SAMPLE_W + CH_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(mclk_in),
    .rst_n_in(resetn_in),
    .ce_in(ce_in),
    .wr(fin.snk),
    .rd(fout.src)
  );

  // output stage register; fifo drains when it is empty or taken
  assign fout.ready = !ov_reg || out_ready_in;

  // capture on every edge, no qualification at the pins
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      a_mant_reg <= MANT_RESET;
      a_exp_reg <= EXP_RESET;
      a_qual_reg <= 1'b0;
      a_qual_prev_reg <= 1'b0;
      b_mant_reg <= MANT_RESET;
      b_exp_reg <= EXP_RESET;
      b_qual_reg <= 1'b0;
      b_qual_prev_reg <= 1'b0;
    end else if (ce_in) begin
      a_mant_reg <= port_a_mantissa_in;
      a_exp_reg <= port_a_exponent_in;
      a_qual_reg <= port_a_sample_qualifier_in;
      a_qual_prev_reg <= a_qual_reg;
      b_mant_reg <= port_b_mantissa_in;
      b_exp_reg <= port_b_exponent_in;
      b_qual_reg <= port_b_sample_qualifier_in;
      b_qual_prev_reg <= b_qual_reg;
    end
  end

  // per-channel holding slot; a new take while full overwrites the held sample and is flagged unless that slot is granted in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ch_valid_reg <= '0;
      ovf_reg <= '0;
      rr_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        ch_data_reg[i] <= '0;
      end
    end else if (ce_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_take[i]) begin
          ch_data_reg[i] <= ch_sample[i];
          ch_valid_reg[i] <= 1'b1;
          if (ch_valid_reg[i] && !(grant && pick == CH_W'(i))) begin
            ovf_reg[i] <= 1'b1;
          end
        end else if (grant && pick == CH_W'(i)) begin
          ch_valid_reg[i] <= 1'b0;
        end
      end
      if (grant) begin
        rr_reg <= pick + 2'd1;
      end
    end
  end

  // compute strobe on every clock, captured or not
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      strobe_reg <= '0;
    end else if (ce_in) begin
      strobe_reg <= '1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      lat_reg <= '0;
    end else if (ce_in) begin
      lat_reg <= dafe_latency(resamp_dec_in, comb_dec_in, fir_tap_count_in);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ov_reg <= 1'b0;
      och_reg <= '0;
      omant_reg <= MANT_RESET;
      oexp_reg <= EXP_RESET;
    end else if (ce_in) begin
      if (fout.ready) begin
        ov_reg <= fout.valid;
        if (fout.valid) begin
          och_reg <= fout.data[SAMPLE_W +: CH_W];
          omant_reg <= fout.data[EXP_W +: MANT_W];
          oexp_reg <= fout.data[EXP_W-1:0];
        end
      end
    end
  end

  assign out_valid_out = ov_reg;
  assign out_channel_out = och_reg;
  assign out_mantissa_out = omant_reg;
  assign out_exponent_out = oexp_reg;
  assign compute_strobe_out = strobe_reg;
  assign overflow_out = ovf_reg;
  assign latency_out = lat_reg;
endmodule // dafe_frontend

/* dafe_frontend_sva.sv */
`timescale 1ns/1ps
module dafe_frontend_sva import dafe_pkg::*; (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic port_a_sample_qualifier_in,
  input wire logic port_b_sample_qualifier_in,
  input wire logic [2*NUM_CH-1:0] ch_qual_mode_in,
  input wire logic [7:0] resamp_dec_in,
  input wire logic [7:0] comb_dec_in,
  input wire logic [7:0] fir_tap_count_in,
  input wire logic out_ready_in,
  input wire logic out_valid_out,
  input wire logic [CH_W-1:0] out_channel_out,
  input wire logic signed [MANT_W-1:0] out_mantissa_out,
  input wire logic [EXP_W-1:0] out_exponent_out,
  input wire logic [NUM_CH-1:0] compute_strobe_out,
  input wire logic [NUM_CH-1:0] overflow_out,
  input wire logic [LAT_W-1:0] latency_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic [15:0] lat_exp;
  logic [4:0] quiet_cnt;
  logic quiet;
  assign lat_exp = 16'(resamp_dec_in) * (16'(comb_dec_in) + 16'h0007)
    + 16'(fir_tap_count_in) + 16'h001A;
  assign quiet = ce_in && out_ready_in && ch_qual_mode_in == 8'hAA
    && !port_a_sample_qualifier_in && !port_b_sample_qualifier_in;
  // saturates so a long idle stretch cannot wrap back under the bound
  always_ff @(posedge mclk_in) begin
    if (!resetn_in || !quiet) quiet_cnt <= 5'h00;
    else if (quiet_cnt != 5'h1F) quiet_cnt <= quiet_cnt + 5'h01;
  end
  sequence stalled_s;
    out_valid_out && !out_ready_in && ce_in;
  endsequence
  sequence held_s;
    out_valid_out && $stable(out_channel_out) && $stable(out_mantissa_out)
      && $stable(out_exponent_out);
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    !resetn_in && ce_in |=> !out_valid_out && compute_strobe_out == 4'h0 && overflow_out == 4'h0)
    else $error("outputs not cleared in reset");
  idle_after_reset_a: assert property ($rose(resetn_in) |-> !out_valid_out [*4])
    else $error("output before pipeline filled");
  strobe_each_a: assert property (ce_in && $past(resetn_in) |=> compute_strobe_out == 4'hF)
    else $error("compute strobe missing");
  stall_hold_a: assert property (stalled_s |=> held_s)
    else $error("output word changed while stalled");
  freeze_hold_a: assert property (!ce_in |=> $stable(out_valid_out) && $stable(overflow_out))
    else $error("state moved with clock enable low");
  latency_calc_a: assert property (ce_in && $past(resetn_in) |=> latency_out == $past(lat_exp))
    else $error("latency value wrong");
  overflow_sticky_a: assert property (overflow_out != 4'h0 |=>
    (overflow_out & $past(overflow_out)) == $past(overflow_out))
    else $error("overflow flag cleared");
  level_quiet_a: assert property (quiet_cnt >= 5'h18 |-> !out_valid_out)
    else $error("sample taken while pins low");
endmodule // dafe_frontend_sva
bind dafe_frontend dafe_frontend_sva u_sva (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .ce_in(ce_in), .port_a_sample_qualifier_in(port_a_sample_qualifier_in),
  .port_b_sample_qualifier_in(port_b_sample_qualifier_in), .ch_qual_mode_in(ch_qual_mode_in),
  .resamp_dec_in(resamp_dec_in), .comb_dec_in(comb_dec_in), .fir_tap_count_in(fir_tap_count_in),
  .out_ready_in(out_ready_in), .out_valid_out(out_valid_out), .out_channel_out(out_channel_out),
  .out_mantissa_out(out_mantissa_out), .out_exponent_out(out_exponent_out),
  .compute_strobe_out(compute_strobe_out), .overflow_out(overflow_out), .latency_out(latency_out));

/* dafe_pkg.sv */
package dafe_pkg;
  localparam int MANT_W = 14;
  localparam int EXP_W = 3;
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int SAMPLE_W = MANT_W + EXP_W;
  localparam int LAT_W = 16;
  localparam logic [LAT_W-1:0] LAT_OFFSET = 16'h001A;
  localparam logic [LAT_W-1:0] LAT_COMB_ADD = 16'h0007;
  localparam logic [MANT_W-1:0] MANT_RESET = 14'h0000;
  localparam logic [EXP_W-1:0] EXP_RESET = 3'h0;

  typedef enum logic [1:0] {
    DAFE_QUAL_FALL = 2'b00,
    DAFE_QUAL_RISE = 2'b01,
    DAFE_QUAL_HIGH = 2'b10,
    DAFE_QUAL_BLANK = 2'b11
  } dafe_qual_e;

  function automatic logic [LAT_W-1:0] dafe_latency(
    input logic [7:0] resamp_dec,
    input logic [7:0] comb_dec,
    input logic [7:0] taps
  );
    logic [LAT_W-1:0] prod;
    prod = LAT_W'(resamp_dec) * (LAT_W'(comb_dec) + LAT_COMB_ADD);
    return prod + LAT_W'(taps) + LAT_OFFSET;
  endfunction
endpackage

/* dafe_stream_if.sv */
`timescale 1ns/1ps
interface dafe_stream_if #(parameter int W = 17);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  import dafe_pkg::*;
  logic mclk_in = 0, resetn_in = 0, ce_in = 1, qa = 0, qb = 0, gain = 0, rdy = 1, stall = 0;
  logic rnd = 0, ov;
  logic [13:0] va = 0, vb = 0, ma, mb;
  logic signed [13:0] om;
  logic [2:0] ex = 0, e_pin, oe;
  logic [3:0] src = 4'hC, cs, ovf;
  logic [7:0] mode = 8'h11, rd = 0, cd = 0, tp = 0;
  logic [1:0] och;
  logic [15:0] lat;
  logic [18:0] q[$];
  int n_errors = 0, checks = 0, cyc = 0;
  always #20 mclk_in = ~mclk_in;
  dafe_adc_model #(.ADC_BITS(12)) adc (.gain_in(gain), .val_a_in(va), .val_b_in(vb),
    .exp_in(ex), .mant_a_out(ma), .mant_b_out(mb), .exp_out(e_pin));
  dafe_frontend dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .port_a_mantissa_in(ma), .port_a_exponent_in(e_pin), .port_a_sample_qualifier_in(qa),
    .port_b_mantissa_in(mb), .port_b_exponent_in(e_pin), .port_b_sample_qualifier_in(qb),
    .ch_src_b_in(src), .ch_qual_mode_in(mode), .resamp_dec_in(rd), .comb_dec_in(cd),
    .fir_tap_count_in(tp), .out_ready_in(rdy), .out_valid_out(ov), .out_channel_out(och),
    .out_mantissa_out(om), .out_exponent_out(oe), .compute_strobe_out(cs),
    .overflow_out(ovf), .latency_out(lat));
  function automatic logic [15:0] lat_f(int r, int c, int t);
    return 16'(r * (c + 7) + t + 26);
  endfunction
  function automatic logic [13:0] nar(logic [13:0] v);
    return {v[13:2], 2'h0};
  endfunction
  task automatic summarize();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // single driver process for ready avoids a race with the test flags
  task automatic tick(int n);
    repeat (n) begin
      @(negedge mclk_in);
      rdy = stall ? 1'b0 : (rnd ? 1'($urandom) : 1'b1);
    end
  endtask
  task automatic edge_t(logic pb, logic lvl, logic [1:0] c);
    logic [13:0] v;
    logic [2:0] e;
    v = 14'($urandom);
    e = 3'($urandom);
    q.delete();
    if (pb) qb = lvl;
    else qa = lvl;
    va = v;
    vb = v;
    ex = e;
    tick(1);
    va = ~v;
    vb = ~v;
    ex = ~e;
    tick(30);
    `CHK(q.size(), 1)
    `CHK(q[0], {c, nar(v), gain ? e : 3'h0})
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (resetn_in && ce_in && ov && rdy) q.push_back({och, om, oe});
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(37));
    tick(20);
    resetn_in = 1;
    for (int i = 0; i < 4; i++) begin
      {rd, cd, tp} = i == 0 ? 24'hFFFFFF : 24'($urandom);
      tick(2);
      `CHK(lat, lat_f(rd, cd, tp))
    end
    `CHK(cs, 4'hF)
    $display("latency test done");
    rnd = 1;
    for (int g = 0; g < 2; g++) begin
      gain = g[0];
      edge_t(0, 1, 0);
      edge_t(0, 0, 1);
      edge_t(1, 1, 2);
      edge_t(1, 0, 3);
    end
    $display("transition test done");
    {rnd, gain, mode} = {2'h0, 8'hFF};
    q.delete();
    repeat (40) begin
      {va, vb, ce_in} = 29'($urandom);
      tick(1);
    end
    ce_in = 1;
    {qa, qb, src, va, vb} = {2'h0, 4'hA, 14'h1234, 14'h2ABC};
    tick(30);
    foreach (q[i]) `CHK(q[i][16:0], 17'h0)
    // raise the pins and let the zero words already queued drain out
    {qa, qb} = 2'h3;
    tick(20);
    q.delete();
    tick(10);
    foreach (q[i]) `CHK(q[i][16:3], src[q[i][18:17]] ? nar(vb) : nar(va))
    $display("blank test done");
    {mode, stall} = {8'hAA, 1'b1};
    tick(20);
    `CHK(ovf, 4'hF)
    {qa, qb, stall} = 3'h0;
    q.delete();
    tick(40);
    `CHK(ov, 1'b0)
    `CHK(q.size() >= 8, 1'b1)
    resetn_in = 0;
    tick(20);
    resetn_in = 1;
    tick(2);
    `CHK(ovf, 4'h0)
    $display("overflow test done");
    summarize();
  end
endmodule // testbench
